/* inc/ctp_pkg.sv */
// Constants, types and decode helpers for the cascadable timer pair
package ctp_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Word offsets on the register port
  localparam logic [3:0] OFF_CTRL_LO = 4'h0;
  localparam logic [3:0] OFF_CTRL_HI = 4'h1;
  localparam logic [3:0] OFF_CNT_LO = 4'h2;
  localparam logic [3:0] OFF_CNT_HI = 4'h3;
  localparam logic [3:0] OFF_PER_LO = 4'h4;
  localparam logic [3:0] OFF_PER_HI = 4'h5;
  localparam logic [3:0] OFF_IRQ_LO = 4'h6;
  localparam logic [3:0] OFF_IRQ_HI = 4'h7;

  // Control field positions
  localparam int BIT_TIMER_RUN = 15;
  localparam int BIT_STOP_IN_IDLE = 13;
  localparam int BIT_GATE_ACC = 6;
  localparam int BIT_PRESCALE_MSB = 5;
  localparam int BIT_PRESCALE_LSB = 4;
  localparam int BIT_CASCADE = 3;
  localparam int BIT_CLOCK_SOURCE = 1;

  // Implemented control bits; all others store and read zero
  localparam logic [15:0] CTRL_LO_MASK = 16'ha07a;
  localparam logic [15:0] CTRL_HI_MASK = 16'ha072;

  // Interrupt control fields
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int IRQ_PRIO_LSB = 2;
  localparam int IRQ_PRIO_MSB = 4;

  // Values after reset
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [4:0] IRQ_RESET = 5'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PRESCALE_TC_1 = 8'h00;
  localparam logic [7:0] PRESCALE_TC_8 = 8'h07;
  localparam logic [7:0] PRESCALE_TC_64 = 8'h3f;
  localparam logic [7:0] PRESCALE_TC_256 = 8'hff;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_GATED = 2'b01,
    MODE_COUNTER = 2'b10
  } ctp_mode_t;

  typedef struct packed {
    logic [15:0] ctrl_lo;
    logic [15:0] ctrl_hi;
    logic [15:0] cnt_lo;
    logic [15:0] cnt_hi;
    logic [15:0] per_lo;
    logic [15:0] per_hi;
    logic [4:0] irqc_lo;
    logic [4:0] irqc_hi;
    logic [2:0] sync_lo;
    logic [2:0] sync_hi;
    logic lvl_lo;
    logic lvl_hi;
    logic retime_lo;
    logic [15:0] read_data;
    logic irq_lo;
    logic irq_hi;
    logic [2:0] prio_lo;
    logic [2:0] prio_hi;
  } ctp_state_t;

  typedef struct packed {
    logic [7:0] count;
  } ctp_pre_state_t;

  localparam ctp_state_t STATE_RESET = '{
    ctrl_lo: CTRL_RESET,
    ctrl_hi: CTRL_RESET,
    cnt_lo: COUNT_RESET,
    cnt_hi: COUNT_RESET,
    per_lo: PERIOD_RESET,
    per_hi: PERIOD_RESET,
    irqc_lo: IRQ_RESET,
    irqc_hi: IRQ_RESET,
    default: '0
  };

  // Mode from clock source and gate bits
  function automatic ctp_mode_t ctp_mode(input logic source, input logic gate);
    if (source)
      ctp_mode = MODE_COUNTER;
    else if (gate)
      ctp_mode = MODE_GATED;
    else
      ctp_mode = MODE_TIMER;
  endfunction : ctp_mode

endpackage : ctp_pkg

/* tb/ctp_pin_source.sv */
// Behavioural source for one external timer clock or gate pin
`timescale 1ns/100ps
module ctp_pin_source (
  output logic pin
);
  // Rests low between bursts, so no stray edge reaches the synchroniser
  initial pin = 1'b0;

  // Rising edges at a half period unrelated in phase to the system clock
  task automatic burst(input int edges, input int half_ns);
    repeat (edges)
    begin
      #(half_ns) pin = 1'b1;
      #(half_ns) pin = 1'b0;
    end
  endtask : burst
endmodule : ctp_pin_source

/* tb/tb_top.sv */
// Self-checking bench for the cascadable timer pair
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [15:0] rexp;
  } ctp_row_t;
  logic clock;
  logic rst;
  logic clock_enable;
  logic [3:0] address;
  logic [15:0] write_data;
  logic write_strobe;
  logic read_strobe;
  logic [15:0] read_data;
  logic idle_mode;
  logic pin_lo;
  logic pin_hi;
  logic irq_lo;
  logic irq_hi;
  logic [2:0] prio_lo;
  logic [2:0] prio_hi;
  int err_total;
  int cmp_count;
  int n;
  logic [15:0] rdv;
  ctp_row_t rows [10];
  int shf [4] = '{0, 3, 6, 8};

  ctp_timer_pair DUT (
    .clock(clock), .rst(rst), .clock_enable(clock_enable), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .idle_mode(idle_mode), .external_timer_clock_pin_low(pin_lo),
    .external_timer_clock_pin_high(pin_hi), .low_irq_request(irq_lo), .high_irq_request(irq_hi),
    .low_irq_priority(prio_lo), .high_irq_priority(prio_hi)
  );
  ctp_pin_source u_src_lo (.pin(pin_lo));
  ctp_pin_source u_src_hi (.pin(pin_hi));

  // 25 MHz system clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Range test for counts whose start phase is not pinned to one cycle
  task automatic inr(input logic [15:0] seen, input int lo, input int hi);
    chk({15'h0, (seen >= lo && seen <= hi) === 1'b1}, 16'h0001);
  endtask : inr

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr

  // Read data are only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    rd(a, rdv);
    chk(rdv, exp);
  endtask : rchk

  // Bounded wait on one request line; returns cycles spent
  task automatic wait_irq(input bit hi, input int lim, output int cyc);
    cyc = 0;
    while ((hi ? irq_hi : irq_lo) !== 1'b1 && cyc < lim)
    begin
      @(posedge clock);
      #1 cyc++;
    end
  endtask : wait_irq

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Watchdog: the sequence needs well under 10000 cycles
  initial
  begin
    #(40 * 30000);
    err_total++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    clock_enable = 1'b1;
    address = 4'h0;
    write_data = 16'h0000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    idle_mode = 1'b0;
    rows = '{'{4'h0, 16'hffff, 16'ha07a}, '{4'h0, 16'h0000, 16'h0000}, '{4'h1, 16'hffff, 16'ha072},
             '{4'h1, 16'h0000, 16'h0000}, '{4'h4, 16'h1234, 16'h1234}, '{4'h5, 16'habcd, 16'habcd},
             '{4'h7, 16'h001e, 16'h001e}, '{4'h7, 16'h0000, 16'h0000}, '{4'h9, 16'hffff, 16'h0000},
             '{4'h2, 16'h0005, 16'h0005}};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // Reset values, periods all ones, unmapped offset reads zero
    for (int i = 0; i < 9; i++)
      rchk(i[3:0], (i == 4 || i == 5) ? 16'hffff : 16'h0000);
    // Write then read back each row; masks drop unimplemented bits
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].rexp);
    end
    wr(ctp_pkg::OFF_PER_LO, 16'hffff);
    // Every prescale code over a fixed run of internal clocks
    for (int c = 0; c < 4; c++)
    begin
      wr(ctp_pkg::OFF_CNT_LO, 16'h0000);
      wr(ctp_pkg::OFF_CTRL_LO, {8'h80, 2'b00, c[1:0], 4'h0});
      repeat (1024) @(posedge clock);
      wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
      rd(ctp_pkg::OFF_CNT_LO, rdv);
      inr(rdv, (1024 >> shf[c]) - 1, (1024 >> shf[c]) + 3);
    end
    // Setup order: period, interrupt, run bit last
    wr(ctp_pkg::OFF_PER_LO, 16'h0004);
    wr(ctp_pkg::OFF_CNT_LO, 16'h0000);
    wr(ctp_pkg::OFF_IRQ_LO, 16'h0006);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8000);
    wait_irq(0, 20, n);
    inr(n[15:0], 4, 8);
    chk({13'h0, prio_lo}, 16'h0001);
    rd(ctp_pkg::OFF_CNT_LO, rdv);
    inr(rdv, 0, 4);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    wr(ctp_pkg::OFF_IRQ_LO, 16'h0006);
    rchk(ctp_pkg::OFF_IRQ_LO, 16'h0006);
    chk({15'h0, irq_lo}, 16'h0000);
    // High timer alone at 1:1, period 2, priority 3
    wr(ctp_pkg::OFF_PER_HI, 16'h0002);
    wr(ctp_pkg::OFF_CNT_HI, 16'h0000);
    wr(ctp_pkg::OFF_IRQ_HI, 16'h000e);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h8000);
    wait_irq(1, 20, n);
    inr(n[15:0], 3, 6);
    chk({13'h0, prio_hi}, 16'h0003);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h0000);
    // Cascade: high control asks 1:256 and must be ignored
    wr(ctp_pkg::OFF_CTRL_HI, 16'h8030);
    wr(ctp_pkg::OFF_CNT_LO, 16'hfff0);
    wr(ctp_pkg::OFF_CNT_HI, 16'h0000);
    wr(ctp_pkg::OFF_PER_LO, 16'h0003);
    wr(ctp_pkg::OFF_PER_HI, 16'h0001);
    wr(ctp_pkg::OFF_IRQ_HI, 16'h001a);
    // Low flag pending, so only cascade muting keeps its request down
    wr(ctp_pkg::OFF_IRQ_LO, 16'h0007);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8008);
    wait_irq(1, 40, n);
    inr(n[15:0], 18, 24);
    chk({15'h0, irq_lo}, 16'h0000);
    chk({13'h0, prio_hi}, 16'h0006);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    rchk(ctp_pkg::OFF_IRQ_HI, 16'h001b);
    rchk(ctp_pkg::OFF_CNT_HI, 16'h0000);
    // Idle: high stop-in-idle still governs the cascaded pair
    wr(ctp_pkg::OFF_PER_HI, 16'hffff);
    wr(ctp_pkg::OFF_CNT_LO, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h2000);
    idle_mode <= 1'b1;
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8008);
    repeat (40) @(posedge clock);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    rchk(ctp_pkg::OFF_CNT_LO, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8008);
    repeat (40) @(posedge clock);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    rd(ctp_pkg::OFF_CNT_LO, rdv);
    inr(rdv, 40, 45);
    idle_mode <= 1'b0;
    // Pin counting on both timers; low gate bit set but must be ignored
    wr(ctp_pkg::OFF_PER_LO, 16'hffff);
    wr(ctp_pkg::OFF_CNT_LO, 16'h0000);
    wr(ctp_pkg::OFF_CNT_HI, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h8002);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8042);
    fork
      u_src_lo.burst(20, 170);
      u_src_hi.burst(20, 190);
    join
    repeat (10) @(posedge clock);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h0000);
    rchk(ctp_pkg::OFF_CNT_LO, 16'h0014);
    rchk(ctp_pkg::OFF_CNT_HI, 16'h0014);
    // Gated: both count only while their pin is high, flag on its fall
    wr(ctp_pkg::OFF_CNT_LO, 16'h0000);
    wr(ctp_pkg::OFF_CNT_HI, 16'h0000);
    wr(ctp_pkg::OFF_IRQ_LO, 16'h0002);
    wr(ctp_pkg::OFF_IRQ_HI, 16'h0002);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h8040);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8040);
    fork
      u_src_lo.burst(1, 800);
      u_src_hi.burst(1, 600);
    join
    wait_irq(0, 12, n);
    inr(n[15:0], 1, 8);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_HI, 16'h0000);
    rd(ctp_pkg::OFF_CNT_LO, rdv);
    inr(rdv, 17, 22);
    rd(ctp_pkg::OFF_CNT_HI, rdv);
    inr(rdv, 13, 17);
    rchk(ctp_pkg::OFF_IRQ_HI, 16'h0003);
    // Enable low freezes a running count; ten cycles run before, two after
    wr(ctp_pkg::OFF_CNT_LO, 16'h0000);
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8000);
    repeat (10) @(posedge clock);
    clock_enable <= 1'b0;
    repeat (50) @(posedge clock);
    clock_enable <= 1'b1;
    wr(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    rd(ctp_pkg::OFF_CNT_LO, rdv);
    inr(rdv, 10, 14);
    // Reset in mid-run while the low timer counts
    wr(ctp_pkg::OFF_CTRL_LO, 16'h8000);
    repeat (5) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rchk(ctp_pkg::OFF_CTRL_LO, 16'h0000);
    rchk(ctp_pkg::OFF_CNT_LO, 16'h0000);
    rchk(ctp_pkg::OFF_PER_LO, 16'hffff);
    finish_test();
  end
endmodule : tb_top

/* verilog/ctp_prescaler.sv */
// Input clock prescaler for one timer of the pair
`timescale 1ns/100ps
module ctp_prescaler (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] prescale_select,
  output logic tick_out
);

  ctp_pkg::ctp_pre_state_t st_reg;
  ctp_pkg::ctp_pre_state_t st_next;
  logic [7:0] limit;

  // Terminal count of the selected ratio
  function automatic logic [7:0] tc_of(input logic [1:0] sel);
    case (sel)
      2'b00: tc_of = ctp_pkg::PRESCALE_TC_1;
      2'b01: tc_of = ctp_pkg::PRESCALE_TC_8;
      2'b10: tc_of = ctp_pkg::PRESCALE_TC_64;
      default: tc_of = ctp_pkg::PRESCALE_TC_256;
    endcase
  endfunction : tc_of

  // Count input ticks, pulse on terminal count
  always_comb
  begin
    st_next = st_reg;
    limit = tc_of(prescale_select);
    tick_out = 1'b0;
    if (clear)
      st_next.count = ctp_pkg::PRESCALE_RESET;
    else if (tick_in)
    begin
      // At or past the limit, so a ratio cut mid-count cannot stall
      if (st_reg.count >= limit)
      begin
        st_next.count = ctp_pkg::PRESCALE_RESET;
        tick_out = 1'b1;
      end
      else
        st_next.count = st_reg.count + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_reg.count <= ctp_pkg::PRESCALE_RESET;
    else if (clock_enable)
      st_reg <= st_next;
  end

endmodule : ctp_prescaler

/* verilog/ctp_timer_pair.sv */
// Pair of 16-bit timers that cascade into one 32-bit timer
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ctp_timer_pair (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic [3:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  input wire logic idle_mode,
  input wire logic external_timer_clock_pin_low,
  input wire logic external_timer_clock_pin_high,
  output logic low_irq_request,
  output logic high_irq_request,
  output logic [2:0] low_irq_priority,
  output logic [2:0] high_irq_priority
);

  ctp_pkg::ctp_state_t st_reg;
  ctp_pkg::ctp_state_t st_next;
  ctp_pkg::ctp_mode_t mode_lo;
  ctp_pkg::ctp_mode_t mode_hi;
  logic mode32;
  logic run_a;
  logic run_b;
  logic chg_lo;
  logic chg_hi;
  logic rise_lo;
  logic rise_hi;
  logic fall_lo;
  logic fall_hi;
  logic pre_in_lo;
  logic pre_in_hi;
  logic pre_out_lo;
  logic pre_out_hi;
  logic tick_lo;
  logic tick_hi;
  logic gfall_lo;
  logic gfall_hi;
  logic wrap_lo;
  logic wrap_hi;
  logic wrap32;

  // Input tick for a mode; gate level or pin edge as needed
  function automatic logic src_tick(input ctp_pkg::ctp_mode_t m, input logic rise, input logic lvl);
    case (m)
      ctp_pkg::MODE_TIMER: src_tick = 1'b1;
      ctp_pkg::MODE_GATED: src_tick = lvl;
      ctp_pkg::MODE_COUNTER: src_tick = rise;
      default: src_tick = 1'b0;
    endcase
  endfunction : src_tick

  // Mode decode; high control bits other than stop-in-idle are moot while cascaded
  assign mode32 = st_reg.ctrl_lo[ctp_pkg::BIT_CASCADE];
  assign mode_lo = ctp_pkg::ctp_mode(st_reg.ctrl_lo[ctp_pkg::BIT_CLOCK_SOURCE],
                                     st_reg.ctrl_lo[ctp_pkg::BIT_GATE_ACC]);
  assign mode_hi = ctp_pkg::ctp_mode(st_reg.ctrl_hi[ctp_pkg::BIT_CLOCK_SOURCE],
                                     st_reg.ctrl_hi[ctp_pkg::BIT_GATE_ACC]);

  // Run gating; the pair obeys low run and high stop-in-idle
  assign run_a = st_reg.ctrl_lo[ctp_pkg::BIT_TIMER_RUN]
                 && !(idle_mode && (mode32 ? st_reg.ctrl_hi[ctp_pkg::BIT_STOP_IN_IDLE]
                                           : st_reg.ctrl_lo[ctp_pkg::BIT_STOP_IN_IDLE]));
  assign run_b = !mode32 && st_reg.ctrl_hi[ctp_pkg::BIT_TIMER_RUN]
                 && !(idle_mode && st_reg.ctrl_hi[ctp_pkg::BIT_STOP_IN_IDLE]);

  // Filtered pin edges; a change counts once stages two and three agree
  assign chg_lo = (st_reg.sync_lo[1] == st_reg.sync_lo[2]) && (st_reg.sync_lo[2] != st_reg.lvl_lo);
  assign chg_hi = (st_reg.sync_hi[1] == st_reg.sync_hi[2]) && (st_reg.sync_hi[2] != st_reg.lvl_hi);
  assign rise_lo = chg_lo && st_reg.sync_lo[2];
  assign rise_hi = chg_hi && st_reg.sync_hi[2];
  assign fall_lo = chg_lo && !st_reg.sync_lo[2];
  assign fall_hi = chg_hi && !st_reg.sync_hi[2];

  // Prescaler feeds; the internal clock is the instruction clock itself
  assign pre_in_lo = run_a && src_tick(mode_lo, rise_lo, st_reg.lvl_lo);
  assign pre_in_hi = run_b && src_tick(mode_hi, rise_hi, st_reg.lvl_hi);

  ctp_prescaler u_pre_lo (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .tick_in(pre_in_lo),
    .clear(!run_a),
    .prescale_select(st_reg.ctrl_lo[ctp_pkg::BIT_PRESCALE_MSB:ctp_pkg::BIT_PRESCALE_LSB]),
    .tick_out(pre_out_lo)
  );

  ctp_prescaler u_pre_hi (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .tick_in(pre_in_hi),
    .clear(!run_b),
    .prescale_select(st_reg.ctrl_hi[ctp_pkg::BIT_PRESCALE_MSB:ctp_pkg::BIT_PRESCALE_LSB]),
    .tick_out(pre_out_hi)
  );

  // Count ticks; pin ticks of the low timer go through a retime stage
  assign tick_lo = (mode_lo == ctp_pkg::MODE_COUNTER) ? (st_reg.retime_lo && run_a) : pre_out_lo;
  assign tick_hi = pre_out_hi;

  // Gate falls while gated and running
  assign gfall_lo = run_a && (mode_lo == ctp_pkg::MODE_GATED) && fall_lo;
  assign gfall_hi = run_b && (mode_hi == ctp_pkg::MODE_GATED) && fall_hi;

  // Period matches
  assign wrap_lo = tick_lo && (st_reg.cnt_lo == st_reg.per_lo);
  assign wrap_hi = tick_hi && (st_reg.cnt_hi == st_reg.per_hi);
  assign wrap32 = tick_lo && ({st_reg.cnt_hi, st_reg.cnt_lo} == {st_reg.per_hi, st_reg.per_lo});

  // Next state: pins, counters, bus and outputs
  always_comb
  begin
    logic set_lo;
    logic set_hi;
    set_lo = 1'b0;
    set_hi = 1'b0;
    st_next = st_reg;
    // Three-stage pin synchronisers; first stage feeds only the second
    st_next.sync_lo = {st_reg.sync_lo[1:0], external_timer_clock_pin_low};
    st_next.sync_hi = {st_reg.sync_hi[1:0], external_timer_clock_pin_high};
    if (chg_lo)
      st_next.lvl_lo = st_reg.sync_lo[2];
    if (chg_hi)
      st_next.lvl_hi = st_reg.sync_hi[2];
    // Retime after the prescaler for the low timer's pin clock
    st_next.retime_lo = pre_out_lo && (mode_lo == ctp_pkg::MODE_COUNTER) && run_a;
    if (mode32)
    begin
      // Cascaded: one 32-bit count, flags land on the high timer
      if (wrap32)
      begin
        st_next.cnt_hi = ctp_pkg::COUNT_RESET;
        st_next.cnt_lo = ctp_pkg::COUNT_RESET;
        set_hi = (mode_lo != ctp_pkg::MODE_GATED);
      end
      else if (tick_lo)
        {st_next.cnt_hi, st_next.cnt_lo} = 32'({st_reg.cnt_hi, st_reg.cnt_lo} + 32'h00000001);
      set_hi = set_hi || gfall_lo;
    end
    else
    begin
      // Separate 16-bit timers
      if (wrap_lo)
      begin
        st_next.cnt_lo = ctp_pkg::COUNT_RESET;
        set_lo = (mode_lo != ctp_pkg::MODE_GATED);
      end
      else if (tick_lo)
        st_next.cnt_lo = st_reg.cnt_lo + 16'h0001;
      if (wrap_hi)
      begin
        st_next.cnt_hi = ctp_pkg::COUNT_RESET;
        set_hi = (mode_hi != ctp_pkg::MODE_GATED);
      end
      else if (tick_hi)
        st_next.cnt_hi = st_reg.cnt_hi + 16'h0001;
      set_lo = set_lo || gfall_lo;
      set_hi = set_hi || gfall_hi;
    end
    // Register writes; a counter write beats the count step
    if (write_strobe)
    begin
      case (address)
        ctp_pkg::OFF_CTRL_LO: st_next.ctrl_lo = write_data & ctp_pkg::CTRL_LO_MASK;
        ctp_pkg::OFF_CTRL_HI: st_next.ctrl_hi = write_data & ctp_pkg::CTRL_HI_MASK;
        ctp_pkg::OFF_CNT_LO: st_next.cnt_lo = write_data;
        ctp_pkg::OFF_CNT_HI: st_next.cnt_hi = write_data;
        ctp_pkg::OFF_PER_LO: st_next.per_lo = write_data;
        ctp_pkg::OFF_PER_HI: st_next.per_hi = write_data;
        ctp_pkg::OFF_IRQ_LO: st_next.irqc_lo = write_data[4:0];
        ctp_pkg::OFF_IRQ_HI: st_next.irqc_hi = write_data[4:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clearing write in the same cycle
    st_next.irqc_lo[ctp_pkg::IRQ_FLAG_BIT] = st_next.irqc_lo[ctp_pkg::IRQ_FLAG_BIT] || set_lo;
    st_next.irqc_hi[ctp_pkg::IRQ_FLAG_BIT] = st_next.irqc_hi[ctp_pkg::IRQ_FLAG_BIT] || set_hi;
    // Read data stand only in the cycle after the strobe
    st_next.read_data = 16'h0000;
    if (read_strobe)
    begin
      case (address)
        ctp_pkg::OFF_CTRL_LO: st_next.read_data = st_reg.ctrl_lo;
        ctp_pkg::OFF_CTRL_HI: st_next.read_data = st_reg.ctrl_hi;
        ctp_pkg::OFF_CNT_LO: st_next.read_data = st_reg.cnt_lo;
        ctp_pkg::OFF_CNT_HI: st_next.read_data = st_reg.cnt_hi;
        ctp_pkg::OFF_PER_LO: st_next.read_data = st_reg.per_lo;
        ctp_pkg::OFF_PER_HI: st_next.read_data = st_reg.per_hi;
        ctp_pkg::OFF_IRQ_LO: st_next.read_data = {11'h000, st_reg.irqc_lo};
        ctp_pkg::OFF_IRQ_HI: st_next.read_data = {11'h000, st_reg.irqc_hi};
        default: st_next.read_data = 16'h0000;
      endcase
    end
    // Requests; the low request is muted while cascaded
    st_next.irq_lo = st_next.irqc_lo[ctp_pkg::IRQ_FLAG_BIT] && st_next.irqc_lo[ctp_pkg::IRQ_ENABLE_BIT]
                     && !st_next.ctrl_lo[ctp_pkg::BIT_CASCADE];
    st_next.irq_hi = st_next.irqc_hi[ctp_pkg::IRQ_FLAG_BIT] && st_next.irqc_hi[ctp_pkg::IRQ_ENABLE_BIT];
    st_next.prio_lo = st_next.irqc_lo[ctp_pkg::IRQ_PRIO_MSB:ctp_pkg::IRQ_PRIO_LSB];
    st_next.prio_hi = st_next.irqc_hi[ctp_pkg::IRQ_PRIO_MSB:ctp_pkg::IRQ_PRIO_LSB];
  end

  // State register; enable low freezes everything
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_reg <= ctp_pkg::STATE_RESET;
    else if (clock_enable)
      st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign read_data = st_reg.read_data;
  assign low_irq_request = st_reg.irq_lo;
  assign high_irq_request = st_reg.irq_hi;
  assign low_irq_priority = st_reg.prio_lo;
  assign high_irq_priority = st_reg.prio_hi;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_unimpl_zero;
    ((st_reg.ctrl_lo & ~ctp_pkg::CTRL_LO_MASK) == 16'h0000)
    && ((st_reg.ctrl_hi & ~ctp_pkg::CTRL_HI_MASK) == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented control bit set");

  property p_stop_holds;
    clock_enable && !st_reg.ctrl_lo[ctp_pkg::BIT_TIMER_RUN] && !write_strobe
    |=> $stable(st_reg.cnt_lo);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("low counter moved while stopped");

  property p_idle_halt;
    clock_enable && idle_mode && st_reg.ctrl_hi[ctp_pkg::BIT_STOP_IN_IDLE] && !write_strobe
    |=> $stable(st_reg.cnt_hi);
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("high counter moved in idle");

  property p_mode32_lo_quiet;
    st_reg.ctrl_lo[ctp_pkg::BIT_CASCADE] |-> !low_irq_request;
  endproperty
  a_mode32_lo_quiet: assert property (p_mode32_lo_quiet) else $error("low request while cascaded");

  property p_wrap16;
    clock_enable && !mode32 && tick_hi && (st_reg.cnt_hi == st_reg.per_hi)
    && (mode_hi != ctp_pkg::MODE_GATED) && !write_strobe
    |=> (st_reg.cnt_hi == 16'h0000) && st_reg.irqc_hi[ctp_pkg::IRQ_FLAG_BIT];
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit period match missed");

  property p_carry32;
    clock_enable && mode32 && tick_lo && !wrap32 && (st_reg.cnt_lo == 16'hffff) && !write_strobe
    |=> (st_reg.cnt_hi == 16'($past(st_reg.cnt_hi) + 16'h0001)) && (st_reg.cnt_lo == 16'h0000);
  endproperty
  a_carry32: assert property (p_carry32) else $error("no carry into high word");

  property p_wrap32;
    clock_enable && mode32 && wrap32 && (mode_lo != ctp_pkg::MODE_GATED) && !write_strobe
    |=> ({st_reg.cnt_hi, st_reg.cnt_lo} == 32'h00000000) && st_reg.irqc_hi[ctp_pkg::IRQ_FLAG_BIT];
  endproperty
  a_wrap32: assert property (p_wrap32) else $error("32-bit period match missed");

  property p_prescale_one;
    run_b && (mode_hi == ctp_pkg::MODE_TIMER)
    && (st_reg.ctrl_hi[ctp_pkg::BIT_PRESCALE_MSB:ctp_pkg::BIT_PRESCALE_LSB] == 2'b00)
    |-> tick_hi;
  endproperty
  a_prescale_one: assert property (p_prescale_one) else $error("1:1 prescale dropped a tick");

  property p_gate_fall;
    clock_enable && gfall_hi |=> st_reg.irqc_hi[ctp_pkg::IRQ_FLAG_BIT];
  endproperty
  a_gate_fall: assert property (p_gate_fall) else $error("gate fall did not flag");

  // Low timer on its own: step, wrap and gate fall
  property p_lo_step;
    clock_enable && !mode32 && tick_lo && !wrap_lo && !write_strobe
    |=> (st_reg.cnt_lo == 16'($past(st_reg.cnt_lo) + 16'h0001));
  endproperty
  a_lo_step: assert property (p_lo_step) else $error("low counter missed a step");

  property p_lo_wrap16;
    clock_enable && !mode32 && wrap_lo && (mode_lo != ctp_pkg::MODE_GATED) && !write_strobe
    |=> (st_reg.cnt_lo == 16'h0000) && st_reg.irqc_lo[ctp_pkg::IRQ_FLAG_BIT];
  endproperty
  a_lo_wrap16: assert property (p_lo_wrap16) else $error("low period match missed");

  property p_gate_fall_lo;
    clock_enable && !mode32 && gfall_lo |=> st_reg.irqc_lo[ctp_pkg::IRQ_FLAG_BIT];
  endproperty
  a_gate_fall_lo: assert property (p_gate_fall_lo) else $error("low gate fall did not flag");

  // Cascade silences the high timer's own prescaler feed and tick
  property p_hi_quiet_32;
    mode32 |-> !pre_in_hi && !tick_hi;
  endproperty
  a_hi_quiet_32: assert property (p_hi_quiet_32) else $error("high timer ran while cascaded");

  // A pin tick of the low timer lags its prescaler by the retime flop
  property p_lo_retime;
    clock_enable && $past(clock_enable) && tick_lo && (mode_lo == ctp_pkg::MODE_COUNTER)
    |-> $past(pre_out_lo);
  endproperty
  a_lo_retime: assert property (p_lo_retime) else $error("low pin tick not retimed");

  // Unimplemented low control bits never leak onto the read port
  property p_read_mask;
    clock_enable && read_strobe && (address == ctp_pkg::OFF_CTRL_LO)
    |=> ((read_data & ~ctp_pkg::CTRL_LO_MASK) == 16'h0000);
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("unimplemented bit read as one");

  c_wrap16: cover property (clock_enable && !mode32 && wrap_hi);
  c_wrap32: cover property (clock_enable && mode32 && wrap32);
  c_gate_fall: cover property (clock_enable && (gfall_lo || gfall_hi));
  c_pin_count: cover property (clock_enable && tick_lo && (mode_lo == ctp_pkg::MODE_COUNTER));
  c_enable_freeze: cover property (!clock_enable && run_a);

endmodule : ctp_timer_pair
